/* File: core/pq_pkg.sv */
// Shared constants and packed types for the watermark packet queue.
package pq_pkg;
    localparam int          PKT_DATA_W         = 16;
    localparam int          CNT_W              = 4;
    localparam int          QUEUE_DEPTH        = 8;
    localparam int          RETRY_LIMIT_CYCLES = 12;
    localparam logic [1:0]  PRIO_TOP           = 2'h3;
    localparam logic [3:0]  RST_LOWEST_WM      = 4'h3;
    localparam logic [3:0]  RST_LOW_WM         = 4'h2;
    localparam logic [3:0]  RST_HIGH_WM        = 4'h1;

    typedef struct packed {
        logic [1:0]            prio;
        logic [PKT_DATA_W-1:0] data;
    } pkt_type;

    typedef struct packed {
        logic [CNT_W-1:0] lowest_prio_threshold;
        logic [CNT_W-1:0] low_prio_threshold;
        logic [CNT_W-1:0] high_prio_threshold;
    } wm_type;
endpackage

/* File: core/prio_watermark_packet_queue.sv */
// Ingress and egress packet queues with priority watermark admission.
`timescale 1ns/100ps
// Function
// - Priority 3 admitted whenever a buffer free.
// - Lower priorities need free count above threshold.
// - Eight-entry queue; nothing admitted at zero free.
// - Thresholds reset to 1, 2, 3.
// - Egress sends in arrival order normally.
// - After retry send oldest highest-priority packet.
// - Powered down: flush egress, accept, discard.
// - Refused ingress packet dropped, retry symbol sent.
// - Retry symbol within 12 cycles of header.
// - Ingress uses own separate thresholds.
// - One crossbar transfer at a time; sender holds.
// - Egress keeps up to eight packets.
// - Full egress refuses; ingress keeps its packet.
module prio_watermark_packet_queue #(
    parameter int DEPTH = pq_pkg::QUEUE_DEPTH
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire logic           powered_down,
    input  wire logic           wm_load,
    input  wire pq_pkg::wm_type ing_wm_in,
    input  wire pq_pkg::wm_type egr_wm_in,
    input  wire logic           rx_hdr_valid,
    input  wire pq_pkg::pkt_type rx_hdr_pkt,
    output logic                retry_symbol_q,
    output logic                sw_out_valid_q,
    output pq_pkg::pkt_type     sw_out_pkt_q,
    input  wire logic           sw_out_ready,
    input  wire logic           sw_in_valid,
    input  wire pq_pkg::pkt_type sw_in_pkt,
    output logic [3:0]          sw_in_permit_q,
    output logic                tx_valid_q,
    output pq_pkg::pkt_type     tx_pkt_q,
    input  wire logic           tx_ready,
    input  wire logic           link_ack,
    input  wire logic           link_retry,
    output logic [pq_pkg::CNT_W-1:0] ing_free_q,
    output logic [pq_pkg::CNT_W-1:0] egr_free_q
);
    localparam int                   PW  = $clog2(DEPTH);
    localparam int                   RETRY_LIM = pq_pkg::RETRY_LIMIT_CYCLES;
    localparam logic [pq_pkg::CNT_W-1:0] DEP = pq_pkg::CNT_W'(DEPTH);

    // Pointers wrap by overflow, so only powers of two that fit the counters are served.
    if (DEPTH < 2 || DEPTH > 15 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two from 2 to 8");
    end

    function automatic logic admit(input logic [1:0] prio,
                                   input logic [pq_pkg::CNT_W-1:0] free,
                                   input pq_pkg::wm_type wm);
        logic [pq_pkg::CNT_W-1:0] th;
        th = (prio == 2'h0) ? wm.lowest_prio_threshold :
             (prio == 2'h1) ? wm.low_prio_threshold : wm.high_prio_threshold;
        if (free == '0) return 1'b0;
        if (prio == pq_pkg::PRIO_TOP) return 1'b1;
        return free > th;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    pq_pkg::wm_type ing_wm_q;
    pq_pkg::wm_type egr_wm_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ing_wm_q <= '{pq_pkg::RST_LOWEST_WM, pq_pkg::RST_LOW_WM, pq_pkg::RST_HIGH_WM};
            egr_wm_q <= '{pq_pkg::RST_LOWEST_WM, pq_pkg::RST_LOW_WM, pq_pkg::RST_HIGH_WM};
        end else if (wm_load) begin
            ing_wm_q <= ing_wm_in;
            egr_wm_q <= egr_wm_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ingress queue: FIFO storage plus the register facing the crossbar.
    pq_pkg::pkt_type           ing_mem_q [DEPTH];
    logic [PW-1:0]             ing_wr_q;
    logic [PW-1:0]             ing_rd_q;
    logic [pq_pkg::CNT_W-1:0]  ing_cnt_q;
    wire  logic ing_admit  = admit(rx_hdr_pkt.prio, ing_free_q, ing_wm_q);
    wire  logic ing_push   = rx_hdr_valid && ing_admit;
    wire  logic ing_refuse = rx_hdr_valid && !ing_admit;
    wire  logic so_load    = (ing_cnt_q != '0) && (!sw_out_valid_q || sw_out_ready);
    wire  logic so_leave   = sw_out_valid_q && sw_out_ready;
    wire  logic [pq_pkg::CNT_W-1:0] ing_free_d = ing_free_q - pq_pkg::CNT_W'(ing_push)
                                               + pq_pkg::CNT_W'(so_leave);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ing_wr_q       <= '0;
            ing_rd_q       <= '0;
            ing_cnt_q      <= '0;
            ing_free_q     <= DEP;
            retry_symbol_q <= 1'b0;
            sw_out_valid_q <= 1'b0;
            sw_out_pkt_q   <= '0;
        end else begin
            if (ing_push) begin
                ing_mem_q[ing_wr_q] <= rx_hdr_pkt;
                ing_wr_q            <= ing_wr_q + PW'(1);
            end
            if (so_load) begin
                sw_out_pkt_q <= ing_mem_q[ing_rd_q];
                ing_rd_q     <= ing_rd_q + PW'(1);
            end
            ing_cnt_q      <= ing_cnt_q + pq_pkg::CNT_W'(ing_push) - pq_pkg::CNT_W'(so_load);
            sw_out_valid_q <= so_load || (sw_out_valid_q && !sw_out_ready);
            ing_free_q     <= ing_free_d;
            retry_symbol_q <= ing_refuse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Egress queue: slots kept until acknowledged so they can be resent.
    logic [DEPTH-1:0]          eg_valid_q;
    logic [DEPTH-1:0]          eg_sent_q;
    logic [pq_pkg::CNT_W-1:0]  eg_age_q [DEPTH];
    pq_pkg::pkt_type           eg_pkt_q [DEPTH];
    logic                      retry_mode_q;
    logic                      tx_v1_q;
    pq_pkg::pkt_type           tx_p1_q;

    wire  logic [DEPTH-1:0] cand    = eg_valid_q & ~eg_sent_q;
    wire  logic [DEPTH-1:0] acked   = eg_valid_q & eg_sent_q;
    wire  logic eg_accept = sw_in_valid && sw_in_permit_q[sw_in_pkt.prio];
    wire  logic eg_insert = eg_accept && !powered_down;
    wire  logic buf_ready = !tx_v1_q;
    wire  logic flush     = powered_down || link_retry;

    logic [PW-1:0] ins_idx, sel_idx, ack_idx;
    logic          sel_any, ack_any;
    always_comb begin
        logic [pq_pkg::CNT_W+1:0] best;
        logic [pq_pkg::CNT_W+1:0] score;
        ins_idx = '0;
        sel_idx = '0;
        ack_idx = '0;
        sel_any = 1'b0;
        ack_any = 1'b0;
        best    = '0;
        score   = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (!eg_valid_q[i]) ins_idx = PW'(i);
        end
        for (int i = 0; i < DEPTH; i++) begin
            score = {retry_mode_q ? eg_pkt_q[i].prio : 2'h0, eg_age_q[i]};
            if (cand[i] && (!sel_any || score > best)) begin
                sel_any = 1'b1;
                sel_idx = PW'(i);
                best    = score;
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (acked[i] && (!ack_any || eg_age_q[i] > eg_age_q[ack_idx])) begin
                ack_any = 1'b1;
                ack_idx = PW'(i);
            end
        end
    end

    wire  logic eg_push   = sel_any && buf_ready && !flush;
    wire  logic eg_retire = link_ack && ack_any && !powered_down;
    wire  logic [pq_pkg::CNT_W-1:0] ret_age = eg_age_q[ack_idx];
    wire  logic [pq_pkg::CNT_W-1:0] egr_free_d =
        powered_down ? DEP : egr_free_q - pq_pkg::CNT_W'(eg_insert) + pq_pkg::CNT_W'(eg_retire);

    for (genvar g = 0; g < DEPTH; g++) begin : g_slot
        wire logic ins_here = eg_insert && (ins_idx == PW'(g));
        wire logic ret_here = eg_retire && (ack_idx == PW'(g));
        wire logic [pq_pkg::CNT_W-1:0] older = pq_pkg::CNT_W'(eg_valid_q[g] && eg_retire
                                                             && eg_age_q[g] > ret_age);
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                eg_valid_q[g] <= 1'b0;
                eg_sent_q[g]  <= 1'b0;
                eg_age_q[g]   <= '0;
                eg_pkt_q[g]   <= '0;
            end else if (powered_down) begin
                eg_valid_q[g] <= 1'b0;
                eg_sent_q[g]  <= 1'b0;
            end else if (ins_here) begin
                eg_valid_q[g] <= 1'b1;
                eg_sent_q[g]  <= 1'b0;
                eg_age_q[g]   <= '0;
                eg_pkt_q[g]   <= sw_in_pkt;
            end else begin
                eg_valid_q[g] <= eg_valid_q[g] && !ret_here;
                eg_sent_q[g]  <= !link_retry && (eg_sent_q[g] || (eg_push && sel_idx == PW'(g)));
                eg_age_q[g]   <= eg_age_q[g] + pq_pkg::CNT_W'(eg_insert) - older;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            egr_free_q     <= DEP;
            sw_in_permit_q <= '0;
            retry_mode_q   <= 1'b0;
        end else begin
            egr_free_q <= egr_free_d;
            for (int p = 0; p < 4; p++) begin
                sw_in_permit_q[p] <= powered_down ||
                                     admit(2'(p), egr_free_d, egr_wm_q);
            end
            retry_mode_q <= !powered_down && (link_retry || (retry_mode_q && !eg_push));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer toward the link; a stall by the link fills it.
    wire logic tx_pop = tx_valid_q && tx_ready;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_valid_q <= 1'b0;
            tx_v1_q    <= 1'b0;
            tx_pkt_q   <= '0;
            tx_p1_q    <= '0;
        end else if (flush) begin
            tx_valid_q <= 1'b0;
            tx_v1_q    <= 1'b0;
        end else if (tx_pop && tx_v1_q) begin
            tx_pkt_q <= tx_p1_q;
            tx_v1_q  <= eg_push;
            tx_p1_q  <= eg_pkt_q[sel_idx];
        end else if (tx_pop || !tx_valid_q) begin
            tx_valid_q <= eg_push;
            tx_pkt_q   <= eg_pkt_q[sel_idx];
        end else if (eg_push) begin
            tx_v1_q <= 1'b1;
            tx_p1_q <= eg_pkt_q[sel_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [DEPTH-1:0] older_vec, better_vec;
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            older_vec[i]  = cand[i] && eg_age_q[i] > eg_age_q[sel_idx];
            better_vec[i] = cand[i] && (eg_pkt_q[i].prio > eg_pkt_q[sel_idx].prio ||
                            (eg_pkt_q[i].prio == eg_pkt_q[sel_idx].prio &&
                             eg_age_q[i] > eg_age_q[sel_idx]));
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    top_admit_a: assert property (rx_hdr_valid && rx_hdr_pkt.prio == pq_pkg::PRIO_TOP &&
        ing_free_q != '0 |=> !retry_symbol_q) else $error("priority 3 packet refused");
    low_admit_a: assert property (rx_hdr_valid && rx_hdr_pkt.prio == 2'h1 &&
        ing_free_q <= ing_wm_q.low_prio_threshold |=> retry_symbol_q)
        else $error("low priority admitted at threshold");
    empty_refuse_a: assert property (rx_hdr_valid && ing_free_q == '0
        |=> retry_symbol_q && ing_cnt_q == $past(ing_cnt_q) - pq_pkg::CNT_W'($past(so_load)))
        else $error("packet admitted with no free buffer");
    wm_reset_a: assert property ($past(rst) |->
        ing_wm_q.high_prio_threshold == pq_pkg::RST_HIGH_WM &&
        egr_wm_q.lowest_prio_threshold == pq_pkg::RST_LOWEST_WM)
        else $error("threshold reset value wrong");
    fcfs_order_a: assert property (eg_push && !retry_mode_q |-> older_vec == '0)
        else $error("egress sent out of arrival order");
    retry_pick_a: assert property (eg_push && retry_mode_q |-> better_vec == '0)
        else $error("retry did not pick oldest highest priority");
    down_flush_a: assert property (powered_down |=> eg_valid_q == '0 && !tx_valid_q &&
        sw_in_permit_q == 4'hf) else $error("powered down port not flushed");
    retry_time_a: assert property (ing_refuse |-> ##[1:RETRY_LIM] retry_symbol_q)
        else $error("retry symbol late");
    eg_full_a: assert property (egr_free_q == '0 && !$past(powered_down)
        |-> sw_in_permit_q == 4'h0) else $error("full egress still permits");
    hold_stall_a: assert property (sw_out_valid_q && !sw_out_ready
        |=> sw_out_valid_q && $stable(sw_out_pkt_q)) else $error("crossbar packet dropped");
    free_count_a: assert property (ing_free_q ==
        DEP - ing_cnt_q - pq_pkg::CNT_W'(sw_out_valid_q)) else $error("free count drift");

    refuse_c: cover property (ing_refuse ##1 retry_symbol_q);
    retry_c:  cover property (link_retry ##[1:8] eg_push);
    down_c:   cover property (powered_down && eg_accept);
    full_c:   cover property (egr_free_q == '0 ##1 tx_v1_q);
endmodule

/* File: verification/link_partner_model.sv */
// Link partner model that stalls the transmit side at random and acknowledges sent packets.
`timescale 1ns/100ps
module link_partner_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic tx_valid_q,
    input  wire logic stall,
    input  wire logic ack_en,
    input  wire logic flush,
    output logic      tx_ready,
    output logic      link_ack
);
    int outstanding = 0;

    // A retry or a power-down leaves nothing outstanding, so no stale acknowledge follows.
    always @(posedge core_clk) begin
        if (rst || flush) begin
            outstanding = 0;
        end else begin
            outstanding = outstanding + int'(tx_valid_q && tx_ready) - int'(link_ack);
        end
    end

    always @(negedge core_clk) begin
        if (rst) begin
            tx_ready <= 1'b0;
            link_ack <= 1'b0;
        end else begin
            tx_ready <= !stall && ($urandom % 4 != 0);
            link_ack <= ack_en && !flush && (outstanding > 0) && ($urandom % 3 == 0);
        end
    end
endmodule

/* File: verification/prio_watermark_packet_queue_tb.sv */
// Self-checking bench for the watermark packet queue and its link partner.
`timescale 1ns/100ps
module prio_watermark_packet_queue_tb;
    logic            core_clk = 1'b0;
    logic            rst = 1'b1;
    logic            powered_down, wm_load, rx_hdr_valid, sw_out_ready, sw_in_valid;
    logic            retry_symbol_q, sw_out_valid_q, tx_valid_q, tx_ready, link_ack;
    logic            link_retry, stall, ack_en, open_out;
    logic            reord = 1'b0;
    logic [3:0]      sw_in_permit_q, ing_free_q, egr_free_q;
    pq_pkg::wm_type  ing_wm_in, egr_wm_in, iw, ew;
    pq_pkg::pkt_type rx_hdr_pkt, sw_in_pkt, sw_out_pkt_q, tx_pkt_q, p;
    pq_pkg::pkt_type iq[$], eq[$];
    bit              sent[$];
    int              n_fail = 0, compares = 0, k;

    prio_watermark_packet_queue #(.DEPTH(8)) prio_watermark_packet_queue_inst (
        .core_clk(core_clk), .rst(rst), .powered_down(powered_down), .wm_load(wm_load),
        .ing_wm_in(ing_wm_in), .egr_wm_in(egr_wm_in), .rx_hdr_valid(rx_hdr_valid),
        .rx_hdr_pkt(rx_hdr_pkt), .retry_symbol_q(retry_symbol_q),
        .sw_out_valid_q(sw_out_valid_q), .sw_out_pkt_q(sw_out_pkt_q),
        .sw_out_ready(sw_out_ready), .sw_in_valid(sw_in_valid), .sw_in_pkt(sw_in_pkt),
        .sw_in_permit_q(sw_in_permit_q), .tx_valid_q(tx_valid_q), .tx_pkt_q(tx_pkt_q),
        .tx_ready(tx_ready), .link_ack(link_ack), .link_retry(link_retry),
        .ing_free_q(ing_free_q), .egr_free_q(egr_free_q));

    link_partner_model link_partner_model_inst (
        .core_clk(core_clk), .rst(rst), .tx_valid_q(tx_valid_q), .stall(stall),
        .ack_en(ack_en), .flush(link_retry | powered_down), .tx_ready(tx_ready),
        .link_ack(link_ack));

    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////////////////
    task check(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function logic admit(input logic [3:0] free, input pq_pkg::wm_type wm, input logic [1:0] pr);
        logic [3:0] t;
        t = (pr == 2'h0) ? wm.lowest_prio_threshold :
            (pr == 2'h1) ? wm.low_prio_threshold : wm.high_prio_threshold;
        return (free != 4'h0) && ((pr == 2'h3) || (free > t));
    endfunction

    function logic [3:0] exp_permit();
        logic [3:0] v;
        for (int i = 0; i < 4; i++) v[i] = admit(4'(8 - eq.size()), ew, 2'(i));
        return powered_down ? 4'hf : v;
    endfunction

    // After a retry the first pick is the oldest of the highest priority, then arrival order.
    function int pick();
        int b;
        b = -1;
        foreach (eq[i]) if (!sent[i] && (b < 0 || (reord && eq[i].prio > eq[b].prio))) b = i;
        return b;
    endfunction

    task hdr(input logic [1:0] pr);
        logic a, r;
        @(negedge core_clk);
        check(ing_free_q, 18'(8 - iq.size()));
        p = 18'($urandom);
        p.prio = pr;
        a = admit(4'(8 - iq.size()), iw, pr);
        if (a) iq.push_back(p);
        rx_hdr_valid = 1'b1;
        rx_hdr_pkt = p;
        sw_out_ready = open_out & 1'($urandom);
        @(negedge core_clk);
        rx_hdr_valid = 1'b0;
        r = retry_symbol_q;
        @(negedge core_clk);
        check(r | retry_symbol_q, !a);
    endtask

    task offer(input logic [1:0] pr);
        @(negedge core_clk);
        check(sw_in_permit_q, exp_permit());
        check(egr_free_q, powered_down ? 18'h8 : 18'(8 - eq.size()));
        check(tx_valid_q & powered_down, 1'b0);
        sw_in_pkt = 18'($urandom);
        sw_in_pkt.prio = pr;
        sw_in_valid = 1'b1;
    endtask

    task load(input pq_pkg::wm_type i, input pq_pkg::wm_type e);
        @(negedge core_clk);
        ing_wm_in = i;
        egr_wm_in = e;
        wm_load = 1'b1;
        @(negedge core_clk);
        wm_load = 1'b0;
        iw = i;
        ew = e;
    endtask

    task results();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (!rst) begin
            if (sw_out_valid_q && sw_out_ready) check(sw_out_pkt_q, iq.pop_front());
            if (link_ack) begin
                k = 0;
                while (k < sent.size() - 1 && !sent[k]) k++;
                eq.delete(k);
                sent.delete(k);
            end
            if (link_retry) begin
                foreach (sent[i]) sent[i] = 1'b0;
                reord = 1'b1;
            end
            if (tx_valid_q && tx_ready) begin
                k = pick();
                check(tx_pkt_q, eq[k]);
                sent[k] = 1'b1;
                reord = 1'b0;
            end
            if (powered_down) begin
                eq.delete();
                sent.delete();
            end else if (sw_in_valid && sw_in_permit_q[sw_in_pkt.prio]) begin
                eq.push_back(sw_in_pkt);
                sent.push_back(1'b0);
            end
        end
    end

    initial begin
        #(25ns * 5000);
        n_fail++;
        results();
    end

    initial begin
        {powered_down, wm_load, rx_hdr_valid, sw_out_ready, sw_in_valid} = 5'h00;
        {link_retry, stall, ack_en, open_out} = 4'h4;
        ing_wm_in = '0;
        egr_wm_in = '0;
        rx_hdr_pkt = '0;
        sw_in_pkt = '0;
        iw = {4'h3, 4'h2, 4'h1};
        ew = iw;
        void'($urandom(32'hd13b));
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        check({sw_in_permit_q, ing_free_q, egr_free_q}, 18'hf88);
        // Ingress fills against a refusing crossbar, then drains under new thresholds.
        repeat (10) hdr(2'($urandom));
        repeat (4) hdr(2'h3);
        load({4'h5, 4'h4, 4'h2}, {4'h4, 4'h3, 4'h1});
        open_out = 1'b1;
        repeat (16) hdr(2'($urandom));
        // Egress fills while the link stalls, sends, is retried, then drains on acknowledges.
        repeat (12) offer(2'($urandom));
        repeat (3) offer(2'h3);
        @(negedge core_clk);
        sw_in_valid = 1'b0;
        stall <= 1'b0;
        repeat (5) @(negedge core_clk);
        stall <= 1'b1;
        repeat (3) @(negedge core_clk);
        link_retry <= 1'b1;
        @(negedge core_clk);
        link_retry <= 1'b0;
        stall <= 1'b0;
        ack_en <= 1'b1;
        repeat (60) @(negedge core_clk);
        // Power-down flushes the egress side and swallows every offer.
        stall <= 1'b1;
        ack_en <= 1'b0;
        repeat (3) offer(2'($urandom));
        powered_down = 1'b1;
        repeat (6) offer(2'($urandom));
        @(negedge core_clk);
        sw_in_valid = 1'b0;
        powered_down = 1'b0;
        repeat (2) offer(2'h0);
        results();
    end
endmodule
